// ==== verilog/cie_pkg.sv ====
// Constants, opcode patterns and helper functions for the instruction execute block.
// Assumes a single 10 MHz clock domain and software access over AXI4-Lite.
// ============================================================
package cie_pkg;
  // ============================================================
  // register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_INSN = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_ACC = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PC = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_STACK = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_FADDR = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_FDATA = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_WDOG = 8'h1c;
  // status field positions
  localparam int ST_CARRY = 0;
  localparam int ST_GLOBAL_IRQ_ENABLE = 1;
  localparam int ST_POWER_DOWN_FLAG_N = 2;
  localparam int ST_EXPIRY_FLAG_N = 3;
  localparam int ST_ASLEEP = 4;
  localparam int ST_BUSY = 5;
  localparam int ST_WAKE = 6;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // widths
  localparam int INSN_W = 14;
  localparam int PC_W = 13;
  localparam int SP_W = 3;
  localparam int STACK_DEPTH = 8;
  localparam int FILE_DEPTH = 128;
  // opcode patterns and masks
  localparam logic [13:0] PAT_STORE = 14'h0080;
  localparam logic [13:0] MSK_STORE = 14'h3f80;
  localparam logic [13:0] PAT_NOP = 14'h0000;
  localparam logic [13:0] MSK_NOP = 14'h3f9f;
  localparam logic [13:0] PAT_RETIRQ = 14'h0009;
  localparam logic [13:0] PAT_RETSUB = 14'h0008;
  localparam logic [13:0] PAT_SLEEP = 14'h0063;
  localparam logic [13:0] MSK_FULL = 14'h3fff;
  localparam logic [13:0] PAT_ROTL = 14'h0d00;
  localparam logic [13:0] PAT_ROTR = 14'h0c00;
  localparam logic [13:0] MSK_FDOP = 14'h3f00;
  localparam logic [13:0] PAT_RETLIT = 14'h3400;
  localparam logic [13:0] MSK_RETLIT = 14'h3c00;
  localparam int DEST_BIT = 7;
  // reset values of the power status flags
  localparam logic POWER_DOWN_FLAG_N_RST = 1'b1;
  localparam logic EXPIRY_FLAG_N_RST = 1'b1;

  typedef enum logic [3:0] {
    OP_NOP, OP_STORE, OP_RETIRQ, OP_RETLIT, OP_RETSUB,
    OP_ROTL, OP_ROTR, OP_SLEEP, OP_OTHER
  } cie_op_e;

  // pattern match under a don't-care mask
  function automatic logic cie_match(input logic [13:0] insn, input logic [13:0] pat,
                                     input logic [13:0] msk);
    return (insn & msk) == pat;
  endfunction

  // rotate through carry, result is {new carry, byte}
  function automatic logic [8:0] cie_rot(input logic [7:0] v, input logic c,
                                         input logic left);
    return left ? {v[7], v[6:0], c} : {v[0], c, v[7:1]};
  endfunction
endpackage

// ==== verilog/cie_dec_if.sv ====
// Decoded-instruction bundle between the core and its decoder.
// Assumes a purely combinational decoder on the far side.
`timescale 1ns/10ps
interface cie_dec_if;
  import cie_pkg::*;
  logic [INSN_W-1:0] insn;
  cie_op_e op;
  logic dest;
  logic [6:0] faddr;
  logic [7:0] lit;
  modport core (output insn, input op, input dest, input faddr, input lit);
  modport dec (input insn, output op, output dest, output faddr, output lit);
endinterface

// ==== verilog/cie_decode.sv ====
// Instruction decoder for the execute subset.
// Assumes the core holds the instruction word stable while it executes.
`timescale 1ns/10ps
module cie_decode
  import cie_pkg::*;
(
  // decoded bundle
  cie_dec_if.dec d
);
  // ============================================================
  // operand fields
  assign d.dest = d.insn[DEST_BIT];
  assign d.faddr = d.insn[6:0];
  assign d.lit = d.insn[7:0];

  // ============================================================
  // opcode classes; exact patterns checked before masked ones
  always_comb begin
    if (cie_match(d.insn, PAT_RETIRQ, MSK_FULL)) d.op = OP_RETIRQ;
    else if (cie_match(d.insn, PAT_RETSUB, MSK_FULL)) d.op = OP_RETSUB;
    else if (cie_match(d.insn, PAT_SLEEP, MSK_FULL)) d.op = OP_SLEEP;
    else if (cie_match(d.insn, PAT_STORE, MSK_STORE)) d.op = OP_STORE;
    else if (cie_match(d.insn, PAT_NOP, MSK_NOP)) d.op = OP_NOP;
    else if (cie_match(d.insn, PAT_ROTL, MSK_FDOP)) d.op = OP_ROTL;
    else if (cie_match(d.insn, PAT_ROTR, MSK_FDOP)) d.op = OP_ROTR;
    else if (cie_match(d.insn, PAT_RETLIT, MSK_RETLIT)) d.op = OP_RETLIT;
    else d.op = OP_OTHER;
  end
endmodule // cie_decode

// ==== verilog/cie_core.sv ====
// Execute core for store, no-op, the three returns, rotates and sleep.
// Assumes an AXI4-Lite master that keeps one write and one read in flight.
`timescale 1ns/10ps
module cie_core
  import cie_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read address and data
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // wake-up and oscillator
  input wire logic wake_event,
  output logic osc_en
);
  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_EXEC2, S_SLEEP} cie_state_e;

  cie_state_e state_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r, osc_en_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, wd_r;
  logic [ADDR_W-1:0] wa_r;
  logic [INSN_W-1:0] insn_r;
  logic [7:0] w_r, wdog_r, presc_r, faddr_r;
  logic carry_r, global_irq_enable_r, power_down_flag_n_r, expiry_flag_n_r;
  logic [PC_W-1:0] pc_r;
  logic [SP_W-1:0] sp_r;
  logic [PC_W-1:0] stack_mem [0:STACK_DEPTH-1];
  logic [7:0] file_mem [0:FILE_DEPTH-1];
  cie_dec_if dif ();

  assign dif.insn = insn_r;
  cie_decode u_dec (.d(dif));

  // ============================================================
  // execute helpers
  logic exec, is_rot, is_ret, mapped_w, refused, sw_wr, sw_idle, wake, wr_fire;
  logic [8:0] rot;
  logic [PC_W-1:0] head;
  assign exec = state_r == S_EXEC;
  assign is_rot = dif.op == OP_ROTL || dif.op == OP_ROTR;
  assign is_ret = dif.op == OP_RETIRQ || dif.op == OP_RETLIT || dif.op == OP_RETSUB;
  assign rot = cie_rot(file_mem[dif.faddr], carry_r, dif.op == OP_ROTL);
  assign head = stack_mem[SP_W'(sp_r - 3'd1)];
  assign wr_fire = !awready_r && !wready_r && !bvalid_r;
  assign mapped_w = wa_r <= OFF_WDOG && wa_r[1:0] == 2'h0 && wa_r != OFF_WDOG;
  // only a status write gets through while asleep; nothing lands mid-instruction
  assign refused = !mapped_w || (state_r != S_IDLE && !(state_r == S_SLEEP && wa_r == OFF_STATUS));
  assign sw_wr = wr_fire && !refused;
  assign sw_idle = sw_wr && state_r == S_IDLE;
  assign wake = state_r == S_SLEEP && (wake_event || (sw_wr && wd_r[ST_WAKE]));

  // ============================================================
  // axi write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      wa_r <= '0;
      wd_r <= '0;
    end else begin
      if (awvalid && awready_r) begin
        awready_r <= 1'b0;
        wa_r <= awaddr;
      end
      if (wvalid && wready_r) begin
        wready_r <= 1'b0;
        wd_r <= wdata;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= refused ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // ============================================================
  // axi read channel, answer one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= RESP_OKAY;
      unique case (araddr)
        OFF_INSN: rdata_r <= 32'(insn_r);
        OFF_ACC: rdata_r <= 32'(w_r);
        OFF_STATUS: rdata_r <= 32'({state_r != S_IDLE && state_r != S_SLEEP,
                                    state_r == S_SLEEP, expiry_flag_n_r, power_down_flag_n_r,
                                    global_irq_enable_r, carry_r});
        OFF_PC: rdata_r <= 32'(pc_r);
        OFF_STACK: rdata_r <= 32'(head);
        OFF_FADDR: rdata_r <= 32'(faddr_r);
        OFF_FDATA: rdata_r <= 32'(file_mem[faddr_r[6:0]]);
        OFF_WDOG: rdata_r <= 32'({presc_r, wdog_r});
        default: begin
          rdata_r <= '0;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ============================================================
  // sequencer; returns spend a second, idle cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= S_IDLE;
      insn_r <= '0;
      osc_en_r <= 1'b1;
    end else begin
      unique case (state_r)
        S_IDLE: if (sw_wr && wa_r == OFF_INSN) begin
          insn_r <= wd_r[INSN_W-1:0];
          state_r <= S_EXEC;
        end
        S_EXEC: begin
          if (is_ret) state_r <= S_EXEC2;
          else if (dif.op == OP_SLEEP) begin
            state_r <= S_SLEEP;
            osc_en_r <= 1'b0;
          end else state_r <= S_IDLE;
        end
        S_EXEC2: state_r <= S_IDLE;
        S_SLEEP: if (wake) begin
          state_r <= S_IDLE;
          osc_en_r <= 1'b1;
        end
      endcase
    end
  end

  // ============================================================
  // accumulator
  always_ff @(posedge aclk) begin
    if (!aresetn) w_r <= '0;
    else if (exec && dif.op == OP_RETLIT) w_r <= dif.lit;
    else if (exec && is_rot && !dif.dest) w_r <= rot[7:0];
    else if (sw_idle && wa_r == OFF_ACC) w_r <= wd_r[7:0];
  end

  // file registers hold no reset, as a real register file
  always_ff @(posedge aclk) begin
    if (exec && dif.op == OP_STORE) file_mem[dif.faddr] <= w_r;
    else if (exec && is_rot && dif.dest) file_mem[dif.faddr] <= rot[7:0];
    else if (sw_idle && wa_r == OFF_FDATA) file_mem[faddr_r[6:0]] <= wd_r[7:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) faddr_r <= '0;
    else if (sw_idle && wa_r == OFF_FADDR) faddr_r <= {1'b0, wd_r[6:0]};
  end

  // ============================================================
  // carry and interrupt enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carry_r <= 1'b0;
      global_irq_enable_r <= 1'b0;
    end else if (exec) begin
      if (is_rot) carry_r <= rot[8];
      if (dif.op == OP_RETIRQ) global_irq_enable_r <= 1'b1;
    end else if (sw_idle && wa_r == OFF_STATUS) begin
      carry_r <= wd_r[ST_CARRY];
      global_irq_enable_r <= wd_r[ST_GLOBAL_IRQ_ENABLE];
    end
  end

  // power status flags, only hardware touches them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_down_flag_n_r <= POWER_DOWN_FLAG_N_RST;
      expiry_flag_n_r <= EXPIRY_FLAG_N_RST;
    end else if (exec && dif.op == OP_SLEEP) begin
      power_down_flag_n_r <= 1'b0;
      expiry_flag_n_r <= 1'b1;
    end
  end

  // watchdog and prescaler; frozen while the oscillator is stopped
  always_ff @(posedge aclk) begin
    if (!aresetn || (exec && dif.op == OP_SLEEP)) begin
      wdog_r <= '0;
      presc_r <= '0;
    end else if (state_r != S_SLEEP) begin
      presc_r <= presc_r + 8'h01;
      if (presc_r == 8'hff) wdog_r <= wdog_r + 8'h01;
    end
  end

  // ============================================================
  // program counter and return stack; the stack wraps when over-popped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_r <= '0;
      sp_r <= '0;
    end else if (exec && is_ret) begin
      pc_r <= head;
      sp_r <= SP_W'(sp_r - 3'd1);
    end else if (exec) pc_r <= PC_W'(pc_r + 13'h0001);
    else if (sw_idle && wa_r == OFF_PC) pc_r <= wd_r[PC_W-1:0];
    else if (sw_idle && wa_r == OFF_STACK) sp_r <= SP_W'(sp_r + 3'd1);
  end

  always_ff @(posedge aclk) begin
    if (sw_idle && wa_r == OFF_STACK) stack_mem[sp_r] <= wd_r[PC_W-1:0];
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign osc_en = osc_en_r;

  // ============================================================
  // checks
  sequence s_ret(cie_op_e o);
    exec && dif.op == o;
  endsequence
  sequence s_sleep_entry;
    exec && dif.op == OP_SLEEP;
  endsequence

  AST_RETIRQ: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ret(OP_RETIRQ) |=> pc_r == $past(head) && state_r == S_EXEC2 ##1 state_r == S_IDLE)
    else $error("return_from_irq did not pop in two cycles");
  AST_IRQ_ENABLE: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ret(OP_RETIRQ) |=> global_irq_enable_r) else $error("global_irq_enable not set");
  AST_ROTL: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && dif.op == OP_ROTL |=> carry_r == $past(file_mem[dif.faddr][7]))
    else $error("rotate left carry wrong");
  AST_DEST: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && is_rot && !dif.dest |=> w_r == $past(rot[7:0])) else $error("rotate to W wrong");
  AST_RETLIT: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ret(OP_RETLIT) |=> w_r == $past(dif.lit) && pc_r == $past(head) ##1 state_r == S_IDLE)
    else $error("return_literal wrong");
  AST_RETSUB: assert property (@(posedge aclk) disable iff (!aresetn)
    s_ret(OP_RETSUB) |=> $stable(carry_r) && $stable(global_irq_enable_r)
      && sp_r == $past(sp_r) - 3'd1)
    else $error("return changed flags or stack");
  AST_SLEEP_WDOG: assert property (@(posedge aclk) disable iff (!aresetn)
    s_sleep_entry |=> wdog_r == 8'h00 && presc_r == 8'h00) else $error("watchdog not cleared");
  AST_SLEEP_FLAGS: assert property (@(posedge aclk) disable iff (!aresetn)
    s_sleep_entry |=> !power_down_flag_n_r && expiry_flag_n_r)
    else $error("power flags wrong after sleep");
  AST_SLEEP_HALT: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == S_SLEEP && !wake |=> state_r == S_SLEEP && !osc_en_r)
    else $error("left sleep without wake");
  AST_STORE: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && dif.op == OP_STORE |=> file_mem[$past(dif.faddr)] == $past(w_r) && $stable(carry_r))
    else $error("store_accumulator wrong");
  AST_ROTR: assert property (@(posedge aclk) disable iff (!aresetn)
    exec && dif.op == OP_ROTR |=> carry_r == $past(file_mem[dif.faddr][0]))
    else $error("rotate right carry wrong");
endmodule // cie_core

// ==== tb/cpu_insn_exec_subset_test.sv ====
// Self-checking bench for the instruction execute core.
// Assumes the core is the only slave on its AXI4-Lite port and this bench the only master.
`timescale 1ns/10ps
module cpu_insn_exec_subset_test;
  import cie_pkg::*;
  // ============================================================
  // signals
  localparam logic [31:0] OKAY32 = {30'h0, RESP_OKAY};
  localparam logic [31:0] ERR32 = {30'h0, RESP_SLVERR};
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, wake_event;
  logic awready, wready, bvalid, arready, rvalid, osc_en;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, rs;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int fails, n_compared;

  cie_core DUT (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .wake_event(wake_event), .osc_en(osc_en)
  );

  // ============================================================
  // clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // ============================================================
  // reporting
  task automatic complete_run();
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // a wait that ran out ends the run as a failure
  task automatic hang();
    fails++;
    complete_run();
  endtask

  // ============================================================
  // bus tasks; bready and rready stay high, which keeps reissue races away
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    while (1) begin
      @(posedge aclk);
      n++;
      if (n > 40) hang();
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rs = {30'h0, bresp};
  endtask

  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    arvalid <= 1'b1;
    araddr <= a;
    while (1) begin
      @(posedge aclk);
      n++;
      if (n > 40) hang();
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rs = {30'h0, rresp};
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    axr(a);
    chk(rd, exp);
  endtask

  // issue one instruction, then poll until the core is no longer busy
  task automatic run_insn(input logic [13:0] op);
    int n;
    axw(OFF_INSN, {18'h0, op});
    n = 0;
    do begin
      axr(OFF_STATUS);
      n++;
      if (n > 20) hang();
    end while (rd[ST_BUSY] !== 1'b0);
  endtask

  // ============================================================
  // scenarios
  task automatic t_reset();
    rdchk(OFF_STATUS, 32'h0000_000c);
    rdchk(OFF_ACC, 32'h0);
    rdchk(OFF_PC, 32'h0);
    chk({31'h0, osc_en}, 32'h1);
  endtask

  // store at both ends of the file range, then two of the four no-op encodings
  task automatic t_store_nop();
    int i;
    logic [6:0] f;
    for (i = 0; i < 2; i++) begin
      f = i ? 7'h7f : 7'h00;
      axw(OFF_ACC, 32'h5a ^ i);
      axw(OFF_STATUS, 32'h1);
      axw(OFF_PC, 32'h10);
      run_insn(PAT_STORE | {7'h0, f});
      axw(OFF_FADDR, {25'h0, f});
      rdchk(OFF_FDATA, 32'h5a ^ i);
      rdchk(OFF_STATUS, 32'h0d);
      rdchk(OFF_PC, 32'h11);
      run_insn(i ? 14'h0060 : PAT_NOP);
      rdchk(OFF_ACC, 32'h5a ^ i);
      rdchk(OFF_STATUS, 32'h0d);
      rdchk(OFF_FDATA, 32'h5a ^ i);
    end
  endtask

  // both directions, both destinations, both carry values
  task automatic t_rotate();
    int i;
    logic [6:0] f;
    logic [7:0] v, res;
    logic c, l, d, nc;
    for (i = 0; i < 4; i++) begin
      l = i[0];
      d = i[1];
      c = i[0] ^ i[1];
      f = (i == 3) ? 7'h7f : 7'(i * 40);
      v = 8'h96 ^ 8'(i);
      {nc, res} = l ? {v, c} : {v[0], c, v[7:1]};
      axw(OFF_FADDR, {25'h0, f});
      axw(OFF_FDATA, {24'h0, v});
      axw(OFF_ACC, 32'h3c);
      axw(OFF_STATUS, {30'h0, 1'b1, c});
      run_insn((l ? PAT_ROTL : PAT_ROTR) | {6'h0, d, f});
      rdchk(OFF_STATUS, {28'h0, 3'b111, nc});
      rdchk(OFF_FDATA, {24'h0, d ? res : v});
      rdchk(OFF_ACC, {24'h0, d ? 8'h3c : res});
    end
  endtask

  // pops come back in reverse order of the pushes
  task automatic t_returns();
    axw(OFF_STATUS, 32'h1);
    axw(OFF_STACK, 32'h0123);
    axw(OFF_STACK, 32'h1abc);
    run_insn(PAT_RETSUB);
    rdchk(OFF_PC, 32'h1abc);
    rdchk(OFF_STATUS, 32'h0d);
    run_insn(14'h37a5);
    rdchk(OFF_PC, 32'h0123);
    rdchk(OFF_ACC, 32'ha5);
    axw(OFF_STACK, 32'h0fed);
    run_insn(PAT_RETIRQ);
    rdchk(OFF_PC, 32'h0fed);
    rdchk(OFF_STATUS, 32'h0f);
  endtask

  // sleep twice: woken once by the pin, once by software
  task automatic t_sleep();
    logic [31:0] pc;
    repeat (300) @(posedge aclk);
    // the watchdog must have counted, or the clear below proves nothing
    axr(OFF_WDOG);
    chk({31'h0, rd[7:0] == 8'h00}, 32'h0);
    run_insn(PAT_SLEEP);
    chk({31'h0, osc_en}, 32'h0);
    rdchk(OFF_STATUS, 32'h1b);
    rdchk(OFF_WDOG, 32'h0);
    axr(OFF_PC);
    pc = rd;
    axw(OFF_ACC, 32'h77);
    chk(rs, ERR32);
    repeat (20) @(posedge aclk);
    rdchk(OFF_PC, pc);
    rdchk(OFF_WDOG, 32'h0);
    wake_event <= 1'b1;
    @(posedge aclk);
    wake_event <= 1'b0;
    @(posedge aclk);
    chk({31'h0, osc_en}, 32'h1);
    rdchk(OFF_STATUS, 32'h0b);
    rdchk(OFF_ACC, 32'ha5);
    run_insn(PAT_SLEEP);
    axw(OFF_STATUS, 32'h40);
    chk(rs, OKAY32);
    repeat (2) @(posedge aclk);
    chk({31'h0, osc_en}, 32'h1);
    rdchk(OFF_STATUS, 32'h0b);
  endtask

  // unmapped and read-only places are refused and leave state alone
  task automatic t_bus_err();
    axw(8'h20, 32'h1);
    chk(rs, ERR32);
    axr(8'h20);
    chk(rs, ERR32);
    chk(rd, 32'h0);
    axw(OFF_WDOG, 32'hff);
    chk(rs, ERR32);
    rdchk(OFF_ACC, 32'ha5);
  endtask

  // ============================================================
  // main sequence
  initial begin
    fails = 0;
    n_compared = 0;
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    bready = 1'b1;
    rready = 1'b1;
    wake_event = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_store_nop();
    t_rotate();
    t_returns();
    t_sleep();
    t_bus_err();
    complete_run();
  end
endmodule // cpu_insn_exec_subset_test
